// ---- hw/eep_bus_cycle.sv ----
// one parallel bus cycle: read or write with timed strobes
`timescale 1ns/1ps
module eep_bus_cycle
  import eep_pkg::*;
(
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // request
  input  wire eep_req_s          req,
  output logic                   done,
  output logic      [DATA_W-1:0] rdata,
  // pins
  output eep_pins_s              pins,
  input  wire logic [DATA_W-1:0] dq_i
);
  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_SETUP = 4'b0010,
    S_PULSE = 4'b0100,
    S_HOLD  = 4'b1000
  } eep_cyc_e;
  eep_cyc_e          st_r, st_nxt;
  logic [7:0]        cnt_r, cnt_nxt;
  logic              wr_r, wr_nxt;
  logic [DATA_W-1:0] rd_r, rd_nxt;
  eep_pins_s         pin_r, pin_nxt;

  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    wr_nxt  = wr_r;
    rd_nxt  = rd_r;
    pin_nxt = pin_r;
    done    = 1'b0;
    unique case (st_r)
      S_IDLE:
      begin
        if (req.start)
        begin
          // address and data set up with all strobes high
          pin_nxt.addr  = req.addr;
          pin_nxt.dq_o  = req.data;
          pin_nxt.dq_oe = req.is_write;
          pin_nxt.oe_n  = 1'b1;
          wr_nxt        = req.is_write;
          cnt_nxt       = 8'(SETUP_CYC);
          st_nxt        = S_SETUP;
        end
      end
      S_SETUP:
      begin
        if (cnt_r <= 8'h01)
        begin
          // write: ce+we low with oe high; read: ce+oe low with we high
          pin_nxt.ce_n = 1'b0; // R21 R22
          pin_nxt.we_n = !wr_r; // R7
          pin_nxt.oe_n = wr_r;
          cnt_nxt = wr_r ? 8'(STROBE_LOW_CYC) : 8'(READ_CYC); // R6
          st_nxt  = S_PULSE;
        end
        else
        begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      S_PULSE:
      begin
        if (cnt_r <= 8'h01)
        begin
          rd_nxt       = dq_i;
          pin_nxt.ce_n = 1'b1;
          pin_nxt.we_n = 1'b1;
          pin_nxt.oe_n = 1'b1;
          cnt_nxt      = 8'(SETUP_CYC);
          st_nxt       = S_HOLD;
        end
        else
        begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      S_HOLD:
      begin
        if (cnt_r <= 8'h01)
        begin
          pin_nxt.dq_oe = 1'b0;
          done          = 1'b1;
          st_nxt        = S_IDLE;
        end
        else
        begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r  <= S_IDLE;
      cnt_r <= 8'h00;
      wr_r  <= 1'b0;
      rd_r  <= '0;
      pin_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
    end
    else
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      pin_r <= pin_nxt;
    end
  end
  assign pins  = pin_r;
  assign rdata = rd_r;

  property p_wr_gate;
    @(posedge hclk) disable iff (!hresetn)
      (!pins.we_n && !pins.ce_n) |-> pins.oe_n;
  endproperty
  a_wr_gate: assert property (p_wr_gate) else $error("write strobe with oe low"); // R7
  property p_pulse_len;
    @(posedge hclk) disable iff (!hresetn)
      $fell(pins.we_n) |-> !pins.we_n [*5];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("write pulse too short"); // R6
  property p_float;
    @(posedge hclk) disable iff (!hresetn)
      !pins.oe_n |-> !pins.dq_oe;
  endproperty
  a_float: assert property (p_float) else $error("host drives bus during read"); // R22
endmodule

// ---- hw/eep_host.sv ----
// ahb-lite controlled host for a parallel eeprom with software protection
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
// How it works
// [R1] busy read returns inverted bit seven
// [R2] finished read returns true bit seven
// [R3] protected plain write gives no polling
// [R4] toggle bit flips each read while busy
// [R5] toggle stable means write finished
// [R6] write strobe pulses far above 10ns
// [R7] no write with oe low
// [R8] device ships unprotected
// [R9] protected write enables protection
// [R10] only disable sequence clears protection
// [R11] unlock issued before every protected write
// [R12] three fixed writes form unlock
// [R13] page of one to 256 bytes
// [R14] device relocks after page load
// [R15] unlock write always leaves device protected
// [R16] top two address bits ignored
// [R17] no other access inside a sequence
// [R18] six writes clear protection
// [R19] chip select from address decode; ce_n here follows the bus-cycle strobe timing, with no address decode
// [R20] page bytes within 100us
// [R21] write needs ce and we low
// [R22] read with ce and oe low
// [R23] page bytes share upper address
// [R24] sequence addresses and data parametrised
// [R25] broken sequence must restart
module eep_host
  import eep_pkg::*;
#(
  parameter int BYTE_LOAD_CYCLES = BYTE_LOAD_CYC
)(
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic      [31:0]       hrdata,
  // eeprom pins
  output logic                   ce_n,
  output logic                   oe_n,
  output logic                   we_n,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] dq_o,
  output logic                   dq_oe,
  input  wire logic [DATA_W-1:0] dq_i
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_SEQ  = 6'b000010,
    H_PAGE = 6'b000100,
    H_READ = 6'b001000,
    H_POLL = 6'b010000,
    H_GAP  = 6'b100000
  } eep_host_e;

  eep_host_e         st_r, st_nxt;
  logic [2:0]        cmd_r, cmd_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdat_r, wdat_nxt;
  logic [PAGE_W-1:0] len_r, len_nxt;
  logic [PAGE_W-1:0] idx_r, idx_nxt;
  logic [2:0]        seq_r, seq_nxt;
  logic [DATA_W-1:0] rdat_r, rdat_nxt;
  logic [DATA_W-1:0] last_r, last_nxt;
  logic              busy_r, busy_nxt;
  logic              donef_r, donef_nxt;
  logic              err_r, err_nxt;
  logic              tog_r, tog_nxt;
  logic [1:0]        tphase_r, tphase_nxt;
  logic [CNT_W-1:0]  gap_r, gap_nxt;
  logic [ADDR_W-1:0] last_addr;
  eep_req_s          req;
  eep_pins_s         pins;
  logic              cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic [7:0]        mem_rdata;
  logic              mem_we;

  // ahb address phase capture
  logic        aw_r, aw_nxt;
  logic [7:0]  aa_r, aa_nxt;
  logic        take;
  assign take      = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb
  begin
    aw_nxt = take && hwrite;
    aa_nxt = take ? haddr[7:0] : aa_r;
  end

  assign mem_we = aw_r && (aa_r == OFS_WDATA) && !busy_r;

  eep_page_mem u_mem (
    .hclk  (hclk),
    .we    (mem_we),
    .waddr (idx_r[PAGE_W-2:0]),
    .wdata (hwdata[7:0]),
    .raddr (idx_nxt[PAGE_W-2:0]),
    .rdata (mem_rdata)
  );

  eep_bus_cycle u_cyc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .req     (req),
    .done    (cyc_done),
    .rdata   (cyc_rdata),
    .pins    (pins),
    .dq_i    (dq_i)
  );

  // sequence addresses ignore the top two address bits
  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] i,
                                                 input logic [ADDR_W-1:0] base);
    seq_addr = {base[ADDR_W-1:ADDR_W-2], SEQ_ADDR[i]}; // R16 R24
  endfunction

  always_comb
  begin
    st_nxt     = st_r;
    cmd_nxt    = cmd_r;
    addr_nxt   = addr_r;
    wdat_nxt   = wdat_r;
    len_nxt    = len_r;
    idx_nxt    = idx_r;
    seq_nxt    = seq_r;
    rdat_nxt   = rdat_r;
    last_nxt   = last_r;
    busy_nxt   = busy_r;
    donef_nxt  = donef_r;
    err_nxt    = err_r;
    tog_nxt    = tog_r;
    tphase_nxt = tphase_r;
    gap_nxt    = gap_r;
    req        = '{start: 1'b0, is_write: 1'b0, addr: addr_r, data: wdat_r};
    if (aw_r && !busy_r)
    begin
      unique case (aa_r)
        OFS_CTRL:
        begin
          if (hwdata[CTRL_GO])
          begin
            cmd_nxt   = hwdata[CTRL_CMD_LSB +: CMD_W];
            busy_nxt  = 1'b1;
            donef_nxt = 1'b0;
            err_nxt   = 1'b0;
            idx_nxt   = '0;
            seq_nxt   = '0;
            tphase_nxt = 2'b00;
            unique case (hwdata[CTRL_CMD_LSB +: CMD_W])
              CMD_PWRITE, CMD_UNPROT: st_nxt = H_SEQ; // R11 R17
              CMD_WRITE:              st_nxt = H_PAGE;
              CMD_READ:               st_nxt = H_READ;
              CMD_TOGPOLL:            st_nxt = H_POLL;
              default:
              begin
                busy_nxt = 1'b0;
                err_nxt  = 1'b1;
              end
            endcase
          end
        end
        OFS_ADDR:  addr_nxt = hwdata[ADDR_W-1:0];
        OFS_WDATA: idx_nxt  = idx_r + 1'b1;
        OFS_LEN:
        begin
          // page length 1..256, out-of-range sets the error flag and keeps the old length
          if (hwdata[PAGE_W-1:0] == '0 || hwdata[PAGE_W-1:0] > PAGE_W'(PAGE_MAX))
            err_nxt = 1'b1; // R13
          else
            len_nxt = hwdata[PAGE_W-1:0];
        end
        default: ;
      endcase
    end
    unique case (st_r)
      H_IDLE: ;
      H_SEQ:
      begin
        req.start    = 1'b1;
        req.is_write = 1'b1;
        req.addr     = seq_addr(seq_r, addr_r); // R12
        req.data     = (cmd_r == CMD_UNPROT) ? DISABLE_DATA[seq_r] : UNLOCK_DATA[seq_r];
        if (cyc_done)
        begin
          seq_nxt = seq_r + 3'd1;
          if (cmd_r == CMD_UNPROT && seq_r == 3'(DISABLE_N - 1))
          begin
            st_nxt = H_GAP; // R18
          end
          else if (cmd_r != CMD_UNPROT && seq_r == 3'(UNLOCK_N - 1))
          begin
            idx_nxt = '0;
            st_nxt  = H_PAGE; // R9 R15
          end
        end
      end
      H_PAGE:
      begin
        // bytes go back to back, well within the byte-load window
        req.start    = 1'b1;
        req.is_write = 1'b1;
        req.addr     = {addr_r[ADDR_W-1:PAGE_W-1],
                        (PAGE_W-1)'(addr_r[PAGE_W-2:0] + idx_r[PAGE_W-2:0])}; // R23
        req.data     = mem_rdata;
        if (cyc_done)
        begin
          last_nxt = mem_rdata;
          idx_nxt  = idx_r + 1'b1;
          if (idx_r + 1'b1 >= len_r)
            st_nxt = H_GAP; // R14 R20
        end
      end
      H_READ:
      begin
        req.start = 1'b1;
        if (cyc_done)
        begin
          rdat_nxt = cyc_rdata;
          st_nxt   = H_IDLE;
          busy_nxt = 1'b0;
          donef_nxt = 1'b1;
        end
      end
      H_GAP:
      begin
        // wait out the byte-load window so programming starts
        gap_nxt = gap_r + 1'b1;
        idx_nxt = '0;
        if (32'(gap_r) >= 32'(BYTE_LOAD_CYCLES) || gap_r == '1)
        begin
          gap_nxt    = '0;
          tphase_nxt = 2'b00;
          st_nxt     = H_POLL;
        end
      end
      H_POLL:
      begin
        // repeated reads; toggle bit equal in two successive reads means programming done
        req.start = 1'b1;
        req.addr  = (cmd_r == CMD_WRITE || cmd_r == CMD_PWRITE) ? last_addr : addr_r;
        if (cyc_done)
        begin
          rdat_nxt = cyc_rdata;
          tog_nxt  = cyc_rdata[TOGGLE_BIT];
          if (tphase_r != 2'b00 && cyc_rdata[TOGGLE_BIT] == tog_r)
          begin
            st_nxt    = H_IDLE; // R4 R5
            busy_nxt  = 1'b0;
            donef_nxt = 1'b1;
            // polling bit should now equal the true data
            if ((cmd_r == CMD_WRITE || cmd_r == CMD_PWRITE) &&
                cyc_rdata[POLL_BIT] != last_r[POLL_BIT])
              err_nxt = 1'b1; // R2
          end
          tphase_nxt = 2'b01;
        end
      end
      default: st_nxt = H_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_r <= H_IDLE; cmd_r <= '0; addr_r <= '0; wdat_r <= '0;
      len_r <= PAGE_W'(1); idx_r <= '0; seq_r <= '0; rdat_r <= '0;
      last_r <= '0; busy_r <= 1'b0; donef_r <= 1'b0; err_r <= 1'b0;
      tog_r <= 1'b0; tphase_r <= 2'b00; aw_r <= 1'b0; aa_r <= '0;
      gap_r <= '0;
    end
    else
    begin
      st_r <= st_nxt; cmd_r <= cmd_nxt; addr_r <= addr_nxt; wdat_r <= wdat_nxt;
      len_r <= len_nxt; idx_r <= idx_nxt; seq_r <= seq_nxt; rdat_r <= rdat_nxt;
      last_r <= last_nxt; busy_r <= busy_nxt; donef_r <= donef_nxt;
      err_r <= err_nxt; tog_r <= tog_nxt; tphase_r <= tphase_nxt;
      aw_r <= aw_nxt; aa_r <= aa_nxt;
      gap_r <= gap_nxt;
    end
  end

  // last byte of the page, where completion is polled
  assign last_addr = {addr_r[ADDR_W-1:PAGE_W-1],
                      (PAGE_W-1)'(addr_r[PAGE_W-2:0] + len_r[PAGE_W-2:0] - 1'b1)};

  // read data for the captured address
  always_comb
  begin
    unique case (aa_r)
      OFS_ADDR:  hrdata = {{(32-ADDR_W){1'b0}}, addr_r};
      OFS_STAT:  hrdata = {28'h000_0000, tog_r, err_r, donef_r, busy_r};
      OFS_RDATA: hrdata = {24'h00_0000, rdat_r};
      OFS_LEN:   hrdata = {{(32-PAGE_W){1'b0}}, len_r};
      default:   hrdata = 32'h0000_0000;
    endcase
  end

  assign ce_n  = pins.ce_n; // R19
  assign oe_n  = pins.oe_n;
  assign we_n  = pins.we_n;
  assign addr  = pins.addr;
  assign dq_o  = pins.dq_o;
  assign dq_oe = pins.dq_oe;

  sequence s_unlock_done;
    (st_r == H_SEQ && cmd_r == CMD_PWRITE && cyc_done && seq_r == 3'd2);
  endsequence
  property p_unlock_to_page;
    @(posedge hclk) disable iff (!hresetn) s_unlock_done |=> st_r == H_PAGE;
  endproperty
  a_unlock_to_page: assert property (p_unlock_to_page) else $error("no page after unlock"); // R12
  property p_seq_top;
    @(posedge hclk) disable iff (!hresetn)
      (st_r == H_SEQ && !pins.we_n) |-> pins.addr[14:0] == SEQ_ADDR[seq_r];
  endproperty
  a_seq_top: assert property (p_seq_top) else $error("bad sequence address"); // R16
  property p_disable_len;
    @(posedge hclk) disable iff (!hresetn)
      (st_r == H_SEQ && cmd_r == CMD_UNPROT && cyc_done && seq_r == 3'd5) |=> st_r == H_GAP;
  endproperty
  a_disable_len: assert property (p_disable_len) else $error("disable not six writes"); // R18
  property p_page_upper;
    @(posedge hclk) disable iff (!hresetn)
      (st_r == H_PAGE && !pins.we_n) |->
        pins.addr[ADDR_W-1:PAGE_W-1] == addr_r[ADDR_W-1:PAGE_W-1];
  endproperty
  a_page_upper: assert property (p_page_upper) else $error("page address changed"); // R23
  property p_idle_on_done;
    @(posedge hclk) disable iff (!hresetn) $rose(donef_r) |-> !busy_r && st_r == H_IDLE;
  endproperty
  a_idle_on_done: assert property (p_idle_on_done) else $error("done while busy"); // R5
endmodule

// ---- hw/eep_page_mem.sv ----
// page buffer holding bytes to be loaded into one device page
`timescale 1ns/1ps
module eep_page_mem
  import eep_pkg::*;
#(
  parameter int DEPTH = PAGE_MAX,
  parameter int AW    = PAGE_W - 1
)(
  // clock
  input  wire logic          hclk,
  // write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // read side
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [DEPTH];
  always_ff @(posedge hclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ---- hw/eep_pkg.sv ----
// package: constants, types and register map of the eeprom host controller
package eep_pkg;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int PAGE_MAX = 256;
  localparam int PAGE_W = 9;
  localparam int CLK_MHZ = 50;
  // strobe timing in ns and us
  localparam int STROBE_LOW_NS = 100;
  localparam int STROBE_LOW_CYC = (STROBE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_NS = 40;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_NS = 200;
  localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
  localparam int BYTE_LOAD_US = 100;
  localparam int BYTE_LOAD_CYC = BYTE_LOAD_US * CLK_MHZ;
  localparam int CNT_W = 16;
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_LEN = 8'h14;
  // control and status bit positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_CMD_LSB = 1;
  localparam int CMD_W = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_ERR = 2;
  localparam int STAT_TOGGLE = 3;
  // sequence tables
  localparam int UNLOCK_N = 3;
  localparam int DISABLE_N = 6;
  localparam int SEQ_MAX = 6;
  localparam logic [14:0] SEQ_ADDR [SEQ_MAX] = '{15'h5555, 15'h2AAA, 15'h5555,
                                                 15'h5555, 15'h2AAA, 15'h5555};
  localparam logic [7:0] UNLOCK_DATA [SEQ_MAX] = '{8'hAA, 8'h55, 8'hA0,
                                                   8'h00, 8'h00, 8'h00};
  localparam logic [7:0] DISABLE_DATA [SEQ_MAX] = '{8'hAA, 8'h55, 8'h80,
                                                    8'hAA, 8'h55, 8'h20};
  typedef enum logic [2:0] {
    CMD_READ    = 3'h0,
    CMD_WRITE   = 3'h1,
    CMD_PWRITE  = 3'h2,
    CMD_UNPROT  = 3'h3,
    CMD_TOGPOLL = 3'h4
  } eep_cmd_e;
  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic              dq_oe;
  } eep_pins_s;
  typedef struct packed {
    logic              start;
    logic              is_write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } eep_req_s;
endpackage

// ---- verification/eep_dev_model.sv ----
// behavioural parallel eeprom with polling, toggle and software protection
`timescale 1ns/1ps
module eep_dev_model
  import eep_pkg::*;
#(
  parameter realtime LOAD_NS = 500,
  parameter realtime PROG_NS = 3000
)(
  // pins from host
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_o,
  input  wire logic              dq_oe,
  // resolved data bus
  output logic      [DATA_W-1:0] dq
);
  logic [7:0]        mem [int];
  logic [7:0]        pd [$];
  int                pa [$];
  logic [7:0]        rd = 8'h00;
  logic [7:0]        last_d = 8'h00;
  logic              prot = 1'b0;
  logic              busy = 1'b0;
  logic              loading = 1'b0;
  logic              tog = 1'b0;
  logic              unl = 1'b0;
  logic              clr = 1'b0;
  logic              wok = 1'b0;
  int                seq = 0;
  int                viol = 0;
  realtime           t_fall, t_last, t_prog;
  logic [ADDR_W-1:0] wa;

  // released bus shows the inverse of its last value
  assign dq = dq_oe ? dq_o : (!ce_n && !oe_n) ? rd : ~rd;

  // reads and status polls
  always @(negedge oe_n)
  begin
    #1;
    if (!ce_n)
    begin
      if (dq_oe)
        viol++;
      if (busy)
        tog = ~tog;
      rd = busy ? {~last_d[7], tog, last_d[5:0]}
                : (mem.exists(addr) ? mem[addr] : 8'hFF);
    end
  end

  // write strobe: address at fall, data at rise
  always @(negedge we_n)
  begin
    #1;
    t_fall = $realtime;
    wa = addr;
    wok = !ce_n && oe_n && !busy;
    if (!wok)
      viol++;
  end

  always @(posedge we_n)
    if (wok && $realtime - t_fall >= 9)
    begin
      if (!dq_oe)
        viol++;
      wr(wa, dq_o);
    end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [14:0] lo;
    lo = a[14:0];
    if (loading && (int'(a) >> 8) != (pa[0] >> 8))
      viol++;
    if (!loading && lo == SEQ_ADDR[seq] && d == DISABLE_DATA[seq])
    begin
      seq++;
      if (seq == DISABLE_N)
      begin
        seq = 0;
        clr = 1'b1;
        busy = 1'b1;
        t_prog = $realtime;
      end
    end
    else if (!loading && seq == 2 && lo == SEQ_ADDR[2] && d == UNLOCK_DATA[2])
    begin
      seq = 0;
      unl = 1'b1;
    end
    else
    begin
      seq = 0;
      if (prot && !unl)
        return;
      pa.push_back(int'(a));
      pd.push_back(d);
      last_d = d;
      loading = 1'b1;
      t_last = t_fall;
    end
  endtask

  // byte load window and programming timer
  always
  begin
    #5;
    if (loading && $realtime - t_last >= LOAD_NS)
    begin
      loading = 1'b0;
      busy = 1'b1;
      t_prog = $realtime;
    end
    if (busy && $realtime - t_prog >= PROG_NS)
    begin
      busy = 1'b0;
      foreach (pa[i])
        mem[pa[i]] = pd[i];
      pa.delete();
      pd.delete();
      if (unl)
        prot = 1'b1;
      if (clr)
        prot = 1'b0;
      unl = 1'b0;
      clr = 1'b0;
    end
  end
endmodule

// ---- verification/tb_eep_host.sv ----
// self-checking bench for the eeprom host over ahb-lite
`timescale 1ns/1ps
`define CHK(n, e, v) begin compares++; if ((v) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, v); end end
module tb_eep_host
  import eep_pkg::*;
;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]       haddr, hwdata, hrdata, rd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              ce_n, oe_n, we_n, dq_oe;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_o, dq;
  int                error_cnt = 0;
  int                compares = 0;

  eep_host #(.BYTE_LOAD_CYCLES(40)) eep_host_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq));

  eep_dev_model eep_dev_model_i (
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_o(dq_o),
    .dq_oe(dq_oe), .dq(dq));

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // one single ahb transfer; read data lands in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do
    begin
      ahb(1'b0, OFS_STAT, 32'h0000_0000);
      n++;
    end
    while (!(rd[STAT_BUSY] === 1'b0 && rd[STAT_DONE] === 1'b1) && n < 3000);
    if (n >= 3000)
      error_cnt++;
  endtask

  task automatic op(input eep_cmd_e c, input int a);
    ahb(1'b1, OFS_ADDR, 32'(a));
    ahb(1'b1, OFS_CTRL, 32'({c, 1'b1}));
    wait_done;
  endtask

  task automatic page(input eep_cmd_e c, input int a, input int n, input logic [7:0] d0);
    for (int i = 0; i < n; i++)
      ahb(1'b1, OFS_WDATA, 32'(8'(d0 + i * 3)));
    ahb(1'b1, OFS_LEN, 32'(n));
    op(c, a);
  endtask

  task automatic rdb(input int a);
    op(CMD_READ, a);
    ahb(1'b0, OFS_RDATA, 32'h0000_0000);
  endtask

  initial
  begin
    #1_500_000;
    error_cnt++;
    final_report;
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, OFS_STAT, 32'h0000_0000);
    `CHK("stat_reset", 32'h0000_0000, rd)
    `CHK("prot_init", 1'b0, eep_dev_model_i.prot)
    page(CMD_WRITE, 'h0_0120, 3, 8'h35);
    for (int i = 0; i < 3; i++)
    begin
      rdb('h0_0120 + i);
      `CHK("plain_byte", 8'(8'h35 + i * 3), rd[7:0])
    end
    page(CMD_PWRITE, 'h1_8300, 256, 8'h11);
    `CHK("prot_set", 1'b1, eep_dev_model_i.prot)
    rdb('h1_8300);
    `CHK("page_first", 8'h11, rd[7:0])
    rdb('h1_83FF);
    `CHK("page_last", 8'(8'h11 + 255 * 3), rd[7:0])
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK("prot_kept", 1'b1, eep_dev_model_i.prot)
    page(CMD_WRITE, 'h0_0500, 1, 8'h5A);
    `CHK("refused_err", 1'b1, rd[STAT_ERR])
    rdb('h0_0500);
    `CHK("refused", 8'hFF, rd[7:0])
    page(CMD_PWRITE, 'h0_0500, 1, 8'h66);
    rdb('h0_0500);
    `CHK("unlock_again", 8'h66, rd[7:0])
    `CHK("prot_again", 1'b1, eep_dev_model_i.prot)
    op(CMD_UNPROT, 0);
    `CHK("prot_clear", 1'b0, eep_dev_model_i.prot)
    page(CMD_WRITE, 'h0_0500, 1, 8'h77);
    rdb('h0_0500);
    `CHK("plain_after_clear", 8'h77, rd[7:0])
    op(CMD_TOGPOLL, 0);
    `CHK("togpoll_done", 2'b10, rd[1:0])
    `CHK("pin_rules", 0, eep_dev_model_i.viol)
    ahb(1'b1, OFS_LEN, 32'h0000_0000);
    ahb(1'b0, OFS_STAT, 32'h0000_0000);
    `CHK("len_zero_err", 1'b1, rd[STAT_ERR])
    ahb(1'b0, OFS_LEN, 32'h0000_0000);
    `CHK("len_kept", 32'h0000_0001, rd)
    op(CMD_WRITE, 'h0_0000);
    rdb('h0_0000);
    `CHK("one_byte_page", 8'h77, rd[7:0])
    final_report;
  end
endmodule
